// ===== logic/adr_cfg.svh
`ifndef ADR_CFG_SVH
`define ADR_CFG_SVH

// Result width of one converter
`define ADR_RESULT_BITS 18
// Flip-flops in each pin synchroniser
`define ADR_SYNC_STAGES 2
// Reset values
`define ADR_RST_SERIAL_OUT 1'b0
`define ADR_RST_SERIAL_OE 1'b0
`define ADR_RST_PIN_LEVEL 1'b0
`define ADR_RST_FLAG 1'b0
`define ADR_RST_DATA_BIT 1'b0

`endif

// ===== logic/adr_chain.sv
`timescale 1ns/10ps
`include "adr_cfg.svh"
// How it works
// - On a conv_trigger rise, chain_in low selects chain operation and chain_in high selects chip-select operation.
// - With chain_in and conv_trigger both low, serial_out is driven low.
// - A conv_trigger rise with the shift clock low starts a conversion in chain operation without busy indication.
// - A conv_trigger rise with the shift clock high starts a conversion in chain operation with busy indication.
// - Without busy indication the result MSB appears on serial_out once conversion ends, then the core idles.
// - Without busy indication each further shift clock fall moves the next result bit out.
// - Each shift clock fall during the data readback loads chain_in into the tail of the shift register so upstream data passes on.
// - Without busy indication a chain of N converters is read with 18 times N shift clocks.
// - Each converter sends its own 18-bit result MSB first.
// - serial_out holds across both shift clock edges, changing only just after a falling edge.
// - With busy indication serial_out goes high only once this and every upstream converter have finished.
// - With busy indication N converters need 18 times N plus one shift clocks, the first one dropping the busy bit.
module adr_chain #(
	parameter int RESULT_BITS = `ADR_RESULT_BITS
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Pins from the host side, asynchronous
	input wire adr_pkg::adr_pins_type pins,
	// Converter core, same clock
	input wire logic conv_done,
	input wire logic [RESULT_BITS-1:0] conv_result,
	output logic conv_start,
	// Serial output pin
	output logic serial_out,
	output logic serial_out_oe,
	// Status
	output logic chain_mode,
	output logic busy_enabled,
	output logic reading
);
	import adr_pkg::*;

	logic [$bits(adr_pins_type)-1:0] pins_sync;
	adr_pins_type pin_s;
	logic conv_prev_q;
	logic sck_prev_q;
	logic conv_rise;
	logic conv_fall;
	logic sck_fall;
	adr_state_type state_q;
	adr_state_type state_d;
	logic busy_en_q;
	logic chain_mode_q;
	logic conv_start_q;
	logic out_d;
	logic oe_d;
	logic load_sr;
	logic shift_sr;
	logic sr_msb;
	logic upstream_ready;
	logic in_idle;
	logic start_take;
	logic start_chain;
	logic start_busy;
	logic read_now;
	logic read_next;

	if (RESULT_BITS < 2) begin : g_check
		$error("adr_chain needs a result of at least two bits");
	end

	// Mode decode at the start edge, shared by the next-state logic and the mode flags
	function automatic logic chain_selected(input logic chain_level);
		return ~chain_level;
	endfunction

	// Busy indication needs chain operation and a high shift clock at the start edge
	function automatic logic busy_selected(input logic chain_level, input logic clk_level);
		return chain_selected(chain_level) & clk_level;
	endfunction

	// Data bits move only in this state, seen both before and after the state register
	function automatic logic is_shifting(input adr_state_type st);
		return st == ADR_READ;
	endfunction

	adr_sync #(
		.WIDTH($bits(adr_pins_type))
	) u_adr_sync (
		.ref_clk(ref_clk),
		.rst(rst),
		.async_in(pins),
		.sync_out(pins_sync)
	);

	assign pin_s = adr_pins_type'(pins_sync);

	// Edge finding runs on synchronised levels only
	assign conv_rise = pin_s.conv_trigger & ~conv_prev_q;
	assign conv_fall = ~pin_s.conv_trigger & conv_prev_q;
	assign sck_fall = ~pin_s.shift_clk & sck_prev_q;

	// The first converter's chain_in is tied low, so it cannot wait on it
	assign upstream_ready = pin_s.first_in_chain | pin_s.chain_in;
	assign in_idle = (state_q == ADR_IDLE);

	// A start edge counts only in idle; rises in any other state are dropped
	assign start_take = in_idle & conv_rise;
	assign start_chain = chain_selected(pin_s.chain_in);
	assign start_busy = busy_selected(pin_s.chain_in, pin_s.shift_clk);
	assign read_now = is_shifting(state_q);
	assign read_next = is_shifting(state_d);

	// Result loads at the end of conversion, MSB at the front
	assign load_sr = (state_q == ADR_CONVERT) & conv_done;
	// Busy bit edge drops the flag only; no data moves on that edge
	assign shift_sr = read_now & sck_fall;

	adr_shreg #(
		.WIDTH(RESULT_BITS)
	) u_adr_shreg (
		.ref_clk(ref_clk),
		.rst(rst),
		.load(load_sr),
		.load_data(conv_result),
		.shift(shift_sr),
		.shift_in(pin_s.chain_in),
		.msb(sr_msb)
	);

	// Next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			ADR_IDLE: begin
				if (conv_rise) begin
					if (start_chain) begin
						state_d = ADR_CONVERT;
					end else begin
						state_d = ADR_CS_HOLD;
					end
				end
			end
			ADR_CONVERT: begin
				// A started conversion always runs to its end
				if (conv_done) begin
					if (!pin_s.conv_trigger) begin
						state_d = ADR_IDLE;
					end else if (busy_en_q) begin
						state_d = ADR_WAIT_CHAIN;
					end else begin
						state_d = ADR_READ;
					end
				end
			end
			ADR_WAIT_CHAIN: begin
				if (conv_fall) begin
					state_d = ADR_IDLE;
				end else if (upstream_ready) begin
					state_d = ADR_BUSY_BIT;
				end
			end
			ADR_BUSY_BIT: begin
				if (conv_fall) begin
					state_d = ADR_IDLE;
				end else if (sck_fall) begin
					state_d = ADR_READ;
				end
			end
			ADR_READ: begin
				// Shifting never stops on a count: upstream bits keep flowing
				if (conv_fall) begin
					state_d = ADR_IDLE;
				end
			end
			ADR_CS_HOLD: begin
				// Chip-select operation is not served: the pin floats until released
				if (conv_fall) begin
					state_d = ADR_IDLE;
				end
			end
			default: begin
				state_d = ADR_IDLE;
			end
		endcase
	end

	// Pin drive, computed from the next state so serial_out moves one cycle after the edge
	always_comb begin
		out_d = 1'b0;
		oe_d = 1'b1;
		case (state_d)
			ADR_IDLE: begin
				oe_d = ~pin_s.chain_in & ~pin_s.conv_trigger;
			end
			ADR_CONVERT: begin
				out_d = 1'b0;
			end
			ADR_WAIT_CHAIN: begin
				out_d = 1'b0;
			end
			ADR_BUSY_BIT: begin
				out_d = 1'b1;
			end
			ADR_READ: begin
				// In the load cycle the register still holds old data
				out_d = load_sr ? conv_result[RESULT_BITS-1] : sr_msb;
			end
			ADR_CS_HOLD: begin
				oe_d = 1'b0;
			end
			default: begin
				oe_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			conv_prev_q <= `ADR_RST_PIN_LEVEL;
		end else begin
			conv_prev_q <= pin_s.conv_trigger;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sck_prev_q <= `ADR_RST_PIN_LEVEL;
		end else begin
			sck_prev_q <= pin_s.shift_clk;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= ADR_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Mode is caught only at the start edge
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			busy_en_q <= `ADR_RST_FLAG;
		end else if (start_take) begin
			busy_en_q <= start_busy;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			chain_mode_q <= `ADR_RST_FLAG;
		end else if (start_take) begin
			chain_mode_q <= start_chain;
		end
	end

	// Chip-select starts never reach the core, so no result is made for them
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			conv_start_q <= `ADR_RST_FLAG;
		end else begin
			conv_start_q <= start_take & start_chain;
		end
	end

	// Pin levels leave a flip-flop, so decode glitches never reach the line
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			serial_out <= `ADR_RST_SERIAL_OUT;
		end else begin
			serial_out <= out_d;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			serial_out_oe <= `ADR_RST_SERIAL_OE;
		end else begin
			serial_out_oe <= oe_d;
		end
	end

	// chain_mode and busy_enabled trail their internal flags by one cycle; reading is taken from the next state and follows state_q
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			chain_mode <= `ADR_RST_FLAG;
		end else begin
			chain_mode <= chain_mode_q;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			busy_enabled <= `ADR_RST_FLAG;
		end else begin
			busy_enabled <= busy_en_q;
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reading <= `ADR_RST_FLAG;
		end else begin
			reading <= read_next;
		end
	end

	assign conv_start = conv_start_q;
endmodule // adr_chain

// ===== logic/adr_pkg.sv
package adr_pkg;
	typedef enum logic [2:0] {
		ADR_IDLE = 3'h0,
		ADR_CONVERT = 3'h1,
		ADR_WAIT_CHAIN = 3'h2,
		ADR_BUSY_BIT = 3'h3,
		ADR_READ = 3'h4,
		ADR_CS_HOLD = 3'h5
	} adr_state_type;

	typedef struct packed {
		logic first_in_chain;
		logic shift_clk;
		logic chain_in;
		logic conv_trigger;
	} adr_pins_type;
endpackage

// ===== logic/adr_shreg.sv
`timescale 1ns/10ps
`include "adr_cfg.svh"
module adr_shreg #(
	parameter int WIDTH = `ADR_RESULT_BITS
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Parallel load
	input wire logic load,
	input wire logic [WIDTH-1:0] load_data,
	// Serial shift
	input wire logic shift,
	input wire logic shift_in,
	output logic msb
);
	logic [WIDTH-1:0] data_q;
	logic [WIDTH-1:0] data_d;

	if (WIDTH < 2) begin : g_check
		$error("adr_shreg needs at least two bits");
	end

	// Load has priority; a shift in the load cycle is meaningless
	assign data_d = load ? load_data : (shift ? {data_q[WIDTH-2:0], shift_in} : data_q);
	assign msb = data_q[WIDTH-1];

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			data_q <= {WIDTH{`ADR_RST_DATA_BIT}};
		end else begin
			data_q <= data_d;
		end
	end
endmodule // adr_shreg

// ===== logic/adr_sync.sv
`timescale 1ns/10ps
`include "adr_cfg.svh"
module adr_sync #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Asynchronous levels in, synchronous levels out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	if (WIDTH < 1) begin : g_check
		$error("adr_sync needs at least one bit");
	end

	// First stage feeds the second stage only
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			meta_q <= {WIDTH{`ADR_RST_PIN_LEVEL}};
			sync_out <= {WIDTH{`ADR_RST_PIN_LEVEL}};
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // adr_sync

// ===== verif/adr_chain_asserts.sv
`timescale 1ns/10ps
module adr_chain_asserts #(
	parameter int RESULT_BITS = 18
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// Watched ports
	input wire adr_pkg::adr_pins_type pins,
	input wire logic conv_done,
	input wire logic [RESULT_BITS-1:0] conv_result,
	input wire logic conv_start,
	input wire logic serial_out,
	input wire logic serial_out_oe,
	input wire logic chain_mode,
	input wire logic busy_enabled,
	input wire logic reading
);
	import adr_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Long enough to cover the synchroniser and the way back to idle
	sequence s_idle_low;
		(!pins.chain_in && !pins.conv_trigger) [*8];
	endsequence
	idle_low_a: assert property (s_idle_low |-> serial_out_oe && !serial_out) else $error("idle");
	start_mode_a: assert property (
		conv_start |=> !conv_start && chain_mode && busy_enabled == $past(pins.shift_clk, 4)) else $error("mode");
	chain_pick_a: assert property (conv_start |-> !$past(pins.chain_in, 3)) else $error("pick");
	msb_first_a: assert property (
		conv_done && chain_mode && !busy_enabled |=> reading && serial_out == $past(conv_result[RESULT_BITS-1]))
		else $error("msb");
	busy_hold_a: assert property (
		conv_done && busy_enabled && !pins.first_in_chain && !pins.chain_in |=> !serial_out) else $error("hold");
	busy_rise_a: assert property (
		$rose(serial_out) && pins.conv_trigger && chain_mode && busy_enabled && !reading
		|-> pins.chain_in || pins.first_in_chain) else $error("rise");
	out_steady_a: assert property (
		reading && $past(reading) && $changed(serial_out) |-> !pins.shift_clk && !$past(pins.shift_clk, 2))
		else $error("steady");
	read_drive_a: assert property (reading |-> serial_out_oe && chain_mode) else $error("drive");
endmodule // adr_chain_asserts

bind adr_chain adr_chain_asserts #(.RESULT_BITS(RESULT_BITS)) u_adr_chain_asserts (.ref_clk(ref_clk), .rst(rst),
	.pins(pins), .conv_done(conv_done), .conv_result(conv_result), .conv_start(conv_start), .serial_out(serial_out),
	.serial_out_oe(serial_out_oe), .chain_mode(chain_mode), .busy_enabled(busy_enabled), .reading(reading));

// ===== verif/adr_chain_test.sv
`timescale 1ns/10ps
module adr_chain_test;
	import adr_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic conv_done = 1'b0;
	logic [17:0] res = 18'h2A5C3;
	logic [17:0] up = 18'h1B0F4;
	adr_pins_type pins;
	logic conv_start, serial_out, serial_out_oe, chain_mode, busy_enabled, reading;
	logic [36:0] got;
	int n_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	always #5 ref_clk = ~ref_clk;
	adr_chain u_adr_chain (.ref_clk(ref_clk), .rst(rst), .pins(pins), .conv_done(conv_done), .conv_result(res),
		.conv_start(conv_start), .serial_out(serial_out), .serial_out_oe(serial_out_oe), .chain_mode(chain_mode),
		.busy_enabled(busy_enabled), .reading(reading));
	adr_host_model u_adr_host_model (.pins(pins), .serial_out(serial_out), .serial_out_oe(serial_out_oe));
	// Converter core with a fixed conversion time
	always @(negedge ref_clk) begin
		if (conv_start === 1'b1) begin
			repeat (20) @(negedge ref_clk);
			conv_done <= 1'b1;
			@(negedge ref_clk);
			conv_done <= 1'b0;
		end
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 6000) begin
			n_errors++;
			close_out();
		end
	end
	task automatic check(input logic [36:0] g, input logic [36:0] e);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic t_idle();
		repeat (10) @(negedge ref_clk);
		check({serial_out_oe, serial_out}, 37'h2);
		$display("test idle done");
	endtask
	task automatic t_single();
		u_adr_host_model.start(1'b0, 1'b1, 1'b0, up);
		u_adr_host_model.read(18, got);
		check(got, {19'h0, res});
		u_adr_host_model.stop();
		$display("test single done");
	endtask
	task automatic t_cut();
		u_adr_host_model.start(1'b0, 1'b1, 1'b0, up);
		u_adr_host_model.read(5, got);
		check(got, {32'h0, res[17:13]});
		u_adr_host_model.stop();
		check({serial_out_oe, serial_out, reading}, 37'h4);
		$display("test cut done");
	endtask
	task automatic t_first_busy();
		u_adr_host_model.start(1'b1, 1'b1, 1'b0, up);
		u_adr_host_model.read(19, got);
		check(got, {18'h0, 1'b1, res});
		u_adr_host_model.stop();
		$display("test first busy done");
	endtask
	task automatic t_cs();
		u_adr_host_model.start(1'b0, 1'b1, 1'b1, up);
		check({chain_mode, serial_out_oe}, 37'h0);
		u_adr_host_model.stop();
		$display("test select done");
	endtask
	task automatic t_chain();
		u_adr_host_model.start(1'b0, 1'b0, 1'b0, up);
		u_adr_host_model.read(36, got);
		check(got, {1'b0, res, up});
		u_adr_host_model.stop();
		$display("test chain done");
	endtask
	task automatic t_busy();
		u_adr_host_model.start(1'b1, 1'b0, 1'b0, up);
		check({chain_mode, busy_enabled}, 37'h3);
		u_adr_host_model.read(37, got);
		check(got, {1'b1, res, up});
		u_adr_host_model.stop();
		$display("test busy done");
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge ref_clk);
		rst = 1'b0;
		t_idle();
		t_single();
		t_cut();
		t_cs();
		t_chain();
		t_busy();
		t_first_busy();
		close_out();
	end
endmodule // adr_chain_test

// ===== verif/adr_host_model.sv
`timescale 1ns/10ps
module adr_host_model (
	// Pins toward the converter
	output adr_pkg::adr_pins_type pins,
	// Serial line back
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	import adr_pkg::*;
	logic [36:0] seq;
	int idx;
	initial pins = '0;
	task automatic start(input logic busy, input logic first, input logic cs, input logic [17:0] up);
		seq = first ? 37'h0 : (busy ? {1'b1, up, 18'h0} : {up, 19'h0});
		idx = 0;
		pins.first_in_chain = first;
		pins.shift_clk = busy;
		pins.chain_in = cs;
		#100;
		pins.conv_trigger = 1'b1;
		#100;
		pins.chain_in = 1'b0;
		// Upstream finishes well after this converter, so the busy bit must wait
		#600;
		pins.chain_in = seq[36];
	endtask
	task automatic read(input int n, output logic [36:0] got);
		int w;
		got = '0;
		w = 0;
		while (pins.shift_clk && !(serial_out_oe && serial_out) && w < 100) begin
			#10;
			w++;
		end
		for (int i = n - 1; i >= 0; i--) begin
			pins.shift_clk = 1'b1;
			#80;
			got[i] = serial_out_oe ? serial_out : 1'bz;
			pins.shift_clk = 1'b0;
			#20;
			idx++;
			pins.chain_in = idx < 37 ? seq[36 - idx] : 1'b0;
			#60;
		end
	endtask
	task automatic stop();
		pins.conv_trigger = 1'b0;
		pins.chain_in = 1'b0;
		pins.shift_clk = 1'b0;
		#200;
	endtask
endmodule // adr_host_model
